/* rpcs_pkg.sv */
// Purpose: shared constants and types of the register page context stack
// Assumes: 8-bit register space, one core clock
// Notes: offsets are byte addresses within the special register space
package rpcs_pkg;

  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DEPTH = 3;

  // register offsets
  localparam logic [7:0] OFS_PAGING_CONTROL = 8'h84;
  localparam logic [7:0] OFS_MIDDLE_ENTRY = 8'h85;
  localparam logic [7:0] OFS_ACTIVE_PAGE = 8'h86;
  localparam logic [7:0] OFS_BOTTOM_ENTRY = 8'hA7;

  // paging control fields
  localparam int unsigned AUTO_PAGE_BIT = 0;
  localparam logic [7:0] PAGING_CONTROL_MASK = 8'h01;

  // values after reset
  localparam logic [7:0] RST_ENTRY = 8'h00;
  localparam logic [7:0] RST_PAGING_CONTROL = 8'h00;
  localparam logic [7:0] RST_RDATA = 8'h00;

  // the two pages that hold distinct registers
  localparam logic [7:0] PAGE_LOW = 8'h00;
  localparam logic [7:0] PAGE_HIGH = 8'h0F;

  typedef enum logic [1:0] {
    RPCS_REGION_RESERVED = 2'b00,
    RPCS_REGION_ALL_PAGES = 2'b01,
    RPCS_REGION_PAGE_LOW = 2'b10,
    RPCS_REGION_PAGE_HIGH = 2'b11
  } rpcs_region_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } rpcs_bus_req_t;

  typedef struct packed {
    logic valid;
    rpcs_region_t region;
    logic [7:0] addr;
  } rpcs_decode_t;

endpackage

/* rpcs_stack_entry.sv */
// Purpose: one byte of the page stack
// Assumes: push and pop are single-cycle pulses from the core
// Notes: a push or pop outranks a software write in the same cycle
`timescale 1ns/1ps
`default_nettype none
module rpcs_stack_entry #(
  parameter logic [7:0] RESET_VALUE = 8'h00
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // stack movement
  input wire logic push,
  input wire logic pop,
  input wire logic [7:0] push_data,
  input wire logic [7:0] pop_data,
  // software access
  input wire logic sw_wr,
  input wire logic [7:0] sw_data,
  // stored value
  output logic [7:0] q
);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= RESET_VALUE; // RL12
    end else if (push) begin
      q <= push_data; // RL6
    end else if (pop) begin
      q <= pop_data; // RL6
    end else if (sw_wr) begin
      q <= sw_data; // RL5
    end
  end

endmodule
`default_nettype wire

/* rpcs_page_decode.sv */
// Purpose: paged address decode of the special register space
// Assumes: active page value comes from the top stack entry
// Notes: result is registered, one cycle after the access
`timescale 1ns/1ps
`default_nettype none
module rpcs_page_decode (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // access to classify
  input wire logic access,
  input wire logic [7:0] addr,
  input wire logic [7:0] page,
  // classification
  output rpcs_pkg::rpcs_decode_t decode
);

  rpcs_pkg::rpcs_region_t next_region;

  function automatic logic is_all_pages(input logic [7:0] a);
    case (a)
      8'h81, 8'h82, 8'h83, 8'h85, 8'h86, 8'h87, 8'h88, 8'h89, 8'h8A, 8'h8B,
      8'h8C, 8'h8D, 8'h8E, 8'h90, 8'hA0, 8'hA7, 8'hA8, 8'hB0, 8'hB6, 8'hB7,
      8'hB8, 8'hD0, 8'hE0, 8'hE6, 8'hE7, 8'hF0: is_all_pages = 1'b1;
      default: is_all_pages = 1'b0;
    endcase
  endfunction

  function automatic logic is_undefined(input logic [7:0] a);
    case (a)
      8'h80, 8'h96, 8'hB3, 8'hB4, 8'hB5, 8'hB9, 8'hBF, 8'hD8, 8'hE5,
      8'hF5: is_undefined = 1'b1;
      default: is_undefined = 1'b0;
    endcase
  endfunction

  always_comb begin
    if (is_all_pages(addr)) begin
      next_region = rpcs_pkg::RPCS_REGION_ALL_PAGES; // RL8
    end else if (is_undefined(addr)) begin
      next_region = rpcs_pkg::RPCS_REGION_RESERVED; // RL9
    end else if (page == rpcs_pkg::PAGE_LOW) begin
      next_region = rpcs_pkg::RPCS_REGION_PAGE_LOW; // RL8
    end else if (page == rpcs_pkg::PAGE_HIGH) begin
      next_region = rpcs_pkg::RPCS_REGION_PAGE_HIGH; // RL8
    end else begin
      next_region = rpcs_pkg::RPCS_REGION_RESERVED; // RL9
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      decode <= '0;
    end else begin
      decode.valid <= access;
      decode.region <= next_region;
      decode.addr <= addr;
    end
  end

endmodule
`default_nettype wire

/* rpcs_page_stack.sv */
// Purpose: three-byte register page context stack with paged decode
// Assumes: core interrupt pulses are on the same clock as the register port
// Notes: read data stand one cycle after the read strobe
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// RL1: every interrupt return copies the bottom entry into the middle entry; a return in the same cycle as an entry pushes instead
// RL2: writing the bottom register replaces the value that next return moves up
// RL3: reading the bottom register returns its value and leaves it unchanged
// RL4: stack is three bytes: active page top, middle, then bottom
// RL5: software access changes only the addressed entry, never shifts the stack
// RL6: only interrupt entry pushes and only interrupt return pops
// RL7: the bottom register decodes at its address on every page
// RL8: active page selects between page 0x0 and 0xF registers; all-page ones match
// RL9: unassigned addresses are reserved; reads give zero, writes are dropped
// RL10: with automatic paging, interrupt entry loads the interrupting peripheral page
// RL11: interrupt return restores the active page from the middle entry
// RL12: all stack entries clear to zero on reset, so page zero is active
module rpcs_page_stack (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire rpcs_pkg::rpcs_bus_req_t bus_req,
  output logic [7:0] rdata,
  // core interrupt entry and return
  input wire logic irq_taken,
  input wire logic [7:0] irq_page,
  input wire logic irq_return,
  // page context and decode
  output logic [7:0] active_register_page,
  output logic [7:0] page_stack_middle_entry,
  output logic [7:0] page_stack_bottom_entry,
  output logic [7:0] paging_control,
  output rpcs_pkg::rpcs_decode_t decode
);

  logic wr_active;
  logic wr_middle;
  logic wr_bottom;
  logic wr_control;
  logic push;
  logic pop;
  logic [7:0] top_push_data;
  logic [7:0] next_rdata;

  // address decode of this block's own registers, page independent
  assign wr_active = bus_req.wr && (bus_req.addr == rpcs_pkg::OFS_ACTIVE_PAGE);
  assign wr_middle = bus_req.wr && (bus_req.addr == rpcs_pkg::OFS_MIDDLE_ENTRY);
  assign wr_bottom = bus_req.wr && (bus_req.addr == rpcs_pkg::OFS_BOTTOM_ENTRY); // RL7
  assign wr_control = bus_req.wr && (bus_req.addr == rpcs_pkg::OFS_PAGING_CONTROL);

  // push wins when entry and return coincide
  assign push = irq_taken; // RL6
  assign pop = irq_return && !irq_taken; // RL6

  // new top page on interrupt entry
  assign top_push_data = paging_control[rpcs_pkg::AUTO_PAGE_BIT] ? irq_page : active_register_page; // RL10

  // top entry is the active page
  rpcs_stack_entry #(
    .RESET_VALUE(rpcs_pkg::RST_ENTRY)
  ) u_top (
    .clk(clk),
    .rst(rst),
    .push(push),
    .pop(pop),
    .push_data(top_push_data),
    .pop_data(page_stack_middle_entry), // RL11
    .sw_wr(wr_active),
    .sw_data(bus_req.wdata),
    .q(active_register_page)
  ); // RL4

  rpcs_stack_entry #(
    .RESET_VALUE(rpcs_pkg::RST_ENTRY)
  ) u_middle (
    .clk(clk),
    .rst(rst),
    .push(push),
    .pop(pop),
    .push_data(active_register_page),
    .pop_data(page_stack_bottom_entry), // RL1
    .sw_wr(wr_middle),
    .sw_data(bus_req.wdata),
    .q(page_stack_middle_entry)
  ); // RL4

  // bottom keeps its value on a pop
  rpcs_stack_entry #(
    .RESET_VALUE(rpcs_pkg::RST_ENTRY)
  ) u_bottom (
    .clk(clk),
    .rst(rst),
    .push(push),
    .pop(pop),
    .push_data(page_stack_middle_entry),
    .pop_data(page_stack_bottom_entry),
    .sw_wr(wr_bottom), // RL2
    .sw_data(bus_req.wdata),
    .q(page_stack_bottom_entry)
  ); // RL4

  // paging control register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      paging_control <= rpcs_pkg::RST_PAGING_CONTROL;
    end else if (wr_control) begin
      paging_control <= bus_req.wdata & rpcs_pkg::PAGING_CONTROL_MASK;
    end
  end

  // read mux, unmapped reads give zero
  always_comb begin
    next_rdata = rpcs_pkg::RST_RDATA;
    if (bus_req.rd) begin
      case (bus_req.addr)
        rpcs_pkg::OFS_ACTIVE_PAGE: next_rdata = active_register_page;
        rpcs_pkg::OFS_MIDDLE_ENTRY: next_rdata = page_stack_middle_entry;
        rpcs_pkg::OFS_BOTTOM_ENTRY: next_rdata = page_stack_bottom_entry; // RL3
        rpcs_pkg::OFS_PAGING_CONTROL: next_rdata = paging_control;
        default: next_rdata = rpcs_pkg::RST_RDATA; // RL9
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= rpcs_pkg::RST_RDATA;
    end else begin
      rdata <= next_rdata;
    end
  end

  // classify each access against the current page
  rpcs_page_decode u_decode (
    .clk(clk),
    .rst(rst),
    .access(bus_req.wr || bus_req.rd),
    .addr(bus_req.addr),
    .page(active_register_page), // RL8
    .decode(decode)
  );

endmodule
`default_nettype wire

/* rpcs_page_stack_props.sv */
// Purpose: port assertions of the page stack
// Assumes: one clock, async active-high reset
// Notes: bound to rpcs_page_stack
`timescale 1ns/1ps
`default_nettype none
module rpcs_page_stack_props (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // watched ports
  input wire rpcs_pkg::rpcs_bus_req_t bus_req,
  input wire logic [7:0] rdata,
  input wire logic irq_taken,
  input wire logic [7:0] irq_page,
  input wire logic irq_return,
  input wire logic [7:0] active_register_page,
  input wire logic [7:0] page_stack_middle_entry,
  input wire logic [7:0] page_stack_bottom_entry,
  input wire logic [7:0] paging_control,
  input wire rpcs_pkg::rpcs_decode_t decode
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire logic [7:0] top = active_register_page;
  wire logic [7:0] mid = page_stack_middle_entry;
  wire logic [7:0] bot = page_stack_bottom_entry;
  wire logic pop = irq_return && !irq_taken;
  wire logic quiet = !irq_taken && !irq_return;
  wire logic at_bot = bus_req.addr == rpcs_pkg::OFS_BOTTOM_ENTRY;
  wire logic at_mid = bus_req.addr == rpcs_pkg::OFS_MIDDLE_ENTRY;
  wire logic at_own = at_bot || at_mid || bus_req.addr == rpcs_pkg::OFS_ACTIVE_PAGE ||
    bus_req.addr == rpcs_pkg::OFS_PAGING_CONTROL;
  property p_pop_mid; pop |=> mid == $past(bot); endproperty
  a_pop_mid: assert property (p_pop_mid) else $error("middle not loaded on return");
  property p_pop_top; pop |=> top == $past(mid) && $stable(bot); endproperty
  a_pop_top: assert property (p_pop_top) else $error("top not restored on return");
  property p_push; irq_taken |=> mid == $past(top) && bot == $past(mid); endproperty
  a_push: assert property (p_push) else $error("stack not shifted on entry");
  property p_auto; irq_taken && paging_control[0] |=> top == $past(irq_page); endproperty
  a_auto: assert property (p_auto) else $error("entry page not loaded");
  property p_wr_bot; quiet && bus_req.wr && at_bot |=> bot == $past(bus_req.wdata) && $stable(top) && $stable(mid);
  endproperty
  a_wr_bot: assert property (p_wr_bot) else $error("bottom write wrong");
  property p_still; quiet && !bus_req.wr |=> $stable(top) && $stable(mid) && $stable(bot); endproperty
  a_still: assert property (p_still) else $error("stack moved without cause");
  property p_rd_bot; bus_req.rd && at_bot |=> rdata == $past(bot); endproperty
  a_rd_bot: assert property (p_rd_bot) else $error("bottom read wrong");
  property p_dec; bus_req.rd || bus_req.wr |=> decode.valid && decode.addr == $past(bus_req.addr); endproperty
  a_dec: assert property (p_dec) else $error("decode missing");
  property p_dec_bot; bus_req.rd && at_bot |=> decode.region == rpcs_pkg::RPCS_REGION_ALL_PAGES; endproperty
  a_dec_bot: assert property (p_dec_bot) else $error("bottom not on all pages");
  property p_wr_mid; quiet && bus_req.wr && at_mid |=>
    mid == $past(bus_req.wdata) && $stable(top) && $stable(bot);
  endproperty
  a_wr_mid: assert property (p_wr_mid) else $error("middle write wrong");
  property p_rd_rsv; bus_req.rd && !at_own |=> rdata == 8'h00; endproperty
  a_rd_rsv: assert property (p_rd_rsv) else $error("reserved read not zero");
endmodule
bind rpcs_page_stack rpcs_page_stack_props rpcs_page_stack_props_inst (.clk, .rst, .bus_req, .rdata, .irq_taken,
  .irq_page, .irq_return, .active_register_page, .page_stack_middle_entry, .page_stack_bottom_entry,
  .paging_control, .decode);
`default_nettype wire

/* rpcs_core_model.sv */
// Purpose: core interrupt entry and return model
// Assumes: bench commands one cycle ahead
// Notes: page toggles when no entry pulse
`timescale 1ns/1ps
`default_nettype none
module rpcs_core_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bench commands
  input wire logic cmd_enter,
  input wire logic cmd_leave,
  input wire logic [7:0] cmd_page,
  // core pulses
  output logic irq_taken,
  output logic [7:0] irq_page,
  output logic irq_return
);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_taken <= 1'b0;
      irq_return <= 1'b0;
      irq_page <= 8'h00;
    end else begin
      irq_taken <= cmd_enter;
      irq_return <= cmd_leave;
      irq_page <= cmd_enter ? cmd_page : ~irq_page;
    end
  end
endmodule
`default_nettype wire

/* rpcs_page_stack_tb.sv */
// Purpose: register and interrupt tests of the page stack
// Assumes: 100 MHz clock
// Notes: core pulses come from rpcs_core_model
`timescale 1ns/1ps
`default_nettype none
module rpcs_page_stack_tb;
  logic clk;
  logic rst;
  rpcs_pkg::rpcs_bus_req_t bus_req;
  rpcs_pkg::rpcs_decode_t dec;
  logic [7:0] rdata, top, mid, bot, ctl, cpage, d, irq_page;
  logic c_in, c_out, irq_taken, irq_return;
  logic [7:0] pg [3] = '{8'h00, 8'h0F, 8'h05};
  logic [1:0] rg [3] = '{2'h2, 2'h3, 2'h0};
  int err_count, checks_done, cycles;
  rpcs_core_model rpcs_core_model_inst (.clk, .rst, .cmd_enter(c_in), .cmd_leave(c_out), .cmd_page(cpage),
    .irq_taken, .irq_page, .irq_return);
  rpcs_page_stack rpcs_page_stack_inst (.clk, .rst, .bus_req, .rdata, .irq_taken, .irq_page, .irq_return,
    .active_register_page(top), .page_stack_middle_entry(mid), .page_stack_bottom_entry(bot),
    .paging_control(ctl), .decode(dec));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      err_count = err_count + 1;
      report_and_stop();
    end
  end
  task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic stk(input logic [7:0] t, input logic [7:0] m, input logic [7:0] b);
    chk("top", top, t);
    chk("middle", mid, m);
    chk("bottom", bot, b);
  endtask
  // tasks start and end on a rising edge; outputs read there still hold the previous cycle's value
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    bus_req <= {a, v, 1'b1, 1'b0};
    @(posedge clk);
    bus_req <= '0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a);
    bus_req <= {a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    bus_req <= '0;
    @(posedge clk);
    d = rdata;
  endtask
  task automatic irq(input logic e, input logic l, input logic [7:0] p);
    c_in <= e;
    c_out <= l;
    cpage <= p;
    @(posedge clk);
    c_in <= 1'b0;
    c_out <= 1'b0;
    @(posedge clk);
    @(posedge clk);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    bus_req = '0;
    c_in = 1'b0;
    c_out = 1'b0;
    cpage = 8'h00;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    stk(8'h00, 8'h00, 8'h00);
    chk("control", ctl, 8'h00);
    rd(8'hA7);
    chk("bottom read", d, 8'h00);
    $display("reset test done");
    wr(8'hA7, 8'h5A);
    rd(8'hA7);
    chk("bottom read", d, 8'h5A);
    wr(8'h85, 8'h33);
    stk(8'h00, 8'h33, 8'h5A);
    rd(8'h85);
    chk("middle read", d, 8'h33);
    wr(8'h80, 8'hFF);
    stk(8'h00, 8'h33, 8'h5A);
    rd(8'h80);
    chk("reserved read", d, 8'h00);
    $display("software test done");
    wr(8'h84, 8'h01);
    chk("control", ctl, 8'h01);
    rd(8'h84);
    chk("control read", d, 8'h01);
    irq(1'b1, 1'b0, 8'h0F);
    stk(8'h0F, 8'h00, 8'h33);
    wr(8'hA7, 8'hC3);
    irq(1'b0, 1'b1, 8'h00);
    stk(8'h00, 8'hC3, 8'hC3);
    irq(1'b1, 1'b1, 8'h0F);
    stk(8'h0F, 8'h00, 8'hC3);
    wr(8'h84, 8'h00);
    irq(1'b1, 1'b0, 8'h55);
    stk(8'h0F, 8'h0F, 8'h00);
    irq(1'b0, 1'b1, 8'h00);
    wr(8'hA7, 8'hC3);
    $display("interrupt test done");
    for (int i = 0; i < 3; i++) begin
      wr(8'h86, pg[i]);
      stk(pg[i], 8'h00, 8'hC3);
      rd(8'h86);
      chk("active read", d, pg[i]);
      rd(8'hA7);
      chk("bottom read", d, 8'hC3);
      rd(8'hA1);
      chk("region", {6'h00, dec.region}, {6'h00, rg[i]});
      chk("decode valid", {7'h00, dec.valid}, 8'h01);
      chk("decode addr", dec.addr, 8'hA1);
      rd(8'h81);
      chk("region", {6'h00, dec.region}, 8'h01);
    end
    $display("decode test done");
    wr(8'h84, 8'h01);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    stk(8'h00, 8'h00, 8'h00);
    chk("control", ctl, 8'h00);
    $display("second reset test done");
    report_and_stop();
  end
endmodule
`default_nettype wire
